// [bdm_pkg.sv]
package bdm_pkg;

    // operating modes, one-hot
    typedef enum logic [2:0] {
        MODE_OFF  = 3'b001,
        MODE_STBY = 3'b010,
        MODE_NORM = 3'b100
    } bdm_mode_t;

    // clock and timing
    localparam int CLK_MHZ          = 40;
    localparam int LOGIC_FILTER_NS  = 400;
    localparam int LOGIC_FILTER_CYC =
        (LOGIC_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int TX_TIMEOUT_US    = 1000;
    localparam int TX_TIMEOUT_CYC   = TX_TIMEOUT_US * CLK_MHZ;

    // index of each synchronised pin in the plain sync vector
    localparam int PIN_TX_DATA  = 0;
    localparam int PIN_TX_EN_N  = 1;
    localparam int PIN_GUARD    = 2;
    localparam int PIN_VCC_OK   = 3;
    localparam int PIN_VCC_UV   = 4;
    localparam int PIN_VIO_UV   = 5;
    localparam int PIN_BUS_RX   = 6;
    localparam int PIN_BUS_ACT  = 7;
    localparam int PIN_WAKE     = 8;
    localparam int PIN_OVERTEMP = 9;
    localparam int PIN_BUS_OC   = 10;
    localparam int PIN_COUNT    = 11;

    // pin defaults, matching the pad pulls when undriven
    localparam logic [PIN_COUNT-1:0] PIN_RST = 11'h002;
    localparam logic STBY_N_RST = 1'b0;

    // event codes queued to the host
    localparam int EVT_COUNT = 6;
    localparam logic [2:0] EVT_WAKE     = 3'h0;
    localparam logic [2:0] EVT_UV_FORCE = 3'h1;
    localparam logic [2:0] EVT_TIMEOUT  = 3'h2;
    localparam logic [2:0] EVT_OVERTEMP = 3'h3;
    localparam logic [2:0] EVT_BUS_ERR  = 3'h4;
    localparam logic [2:0] EVT_GUARD    = 3'h5;
    localparam int EVT_FIFO_DEPTH = 4;

    typedef struct packed {
        logic [2:0] code;
    } bdm_event_t;

    typedef struct packed {
        bdm_mode_t mode;
        logic      uv_flag;
        logic      uv_forced;
        logic      wake;
        logic      tx_timeout;
        logic      overtemp;
        logic      bus_error;
        logic      guardian_block;
        logic      bus_activity_flag;
    } bdm_status_t;

    localparam bdm_status_t STATUS_RST = '{
        mode: MODE_OFF, default: 1'b0};

endpackage : bdm_pkg

// [bdm_sync_filt.sv]
module bdm_sync_filt
    import bdm_pkg::*;
#(
    parameter int   FILT_CYC = 1,
    parameter logic RST_VAL  = 1'b0
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic async_i,
    output logic      level_o
);
    localparam int CW = $clog2(FILT_CYC + 1);

    logic          meta_reg;
    logic          sync_reg;
    logic          level_reg;
    logic          level_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    // output moves only after FILT_CYC equal samples, so short spikes die
    always_comb begin
        level_next = level_reg;
        cnt_next   = '0;
        if (sync_reg != level_reg) begin
            if (cnt_reg == CW'(FILT_CYC - 1)) begin
                level_next = sync_reg;
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            meta_reg  <= RST_VAL;
            sync_reg  <= RST_VAL;
            level_reg <= RST_VAL;
            cnt_reg   <= '0;
        end else begin
            meta_reg  <= async_i;
            sync_reg  <= meta_reg;
            level_reg <= level_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level_o = level_reg;

endmodule : bdm_sync_filt

// [bdm_fifo.sv]
module bdm_fifo
    import bdm_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                        : wr_ptr_reg + AW'(1);
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                        : rd_ptr_reg + AW'(1);
        end
        count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // storage needs no reset: count guards every read
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

endmodule : bdm_fifo

// [bdm_mode_ctrl.sv]
// How it works
// - tx_enable_n low permits drive; default high
// - guardian_enable high needed; default low blocks
// - standby_n high selects normal; default standby
// - diag_out_n low on failure or wake
// - bus idle, data_1 plus high, data_0 minus high
// - modes normal, standby, off with fixed causes
// - power-up always lands in standby
// - normal undervoltage flagged and forces standby
// - undervoltage recovery returns to normal if requested
// - normal entered only with command and good supplies
// - main supply loss enters off from anywhere
// - normal: rx follows bus, tx data drives
// - timeout, overtemp, bus error only while transmitting
// - normal updates bus activity flag
// - normal mode never flags wake-up
// - standby ignores tx data and enable
// - standby rx shows wake or error per command
// - standby freezes guardian, activity flag, bus faults
// - standby command: wake shown on diag and rx
// - undervoltage-forced standby flagged and stored
// - transmit starts after enable falls with guardian high
// - guardian low stops transmitter at once
// - off: rx and diag low, serial out released
// - short standby_n pulses filtered out
module bdm_mode_ctrl
    import bdm_pkg::*;
#(
    parameter int TX_TO_CYC   = TX_TIMEOUT_CYC,
    parameter int FILTER_CYC  = LOGIC_FILTER_CYC,
    parameter int FIFO_DEPTH  = EVT_FIFO_DEPTH
) (
    input  wire logic  sys_clk_i,
    input  wire logic  rst_b_i,
    input  wire logic  tx_data_i,
    input  wire logic  tx_enable_n_i,
    input  wire logic  guardian_enable_i,
    input  wire logic  standby_n_i,
    input  wire logic  vcc_ok_i,
    input  wire logic  vcc_uv_i,
    input  wire logic  logic_ref_supply_uv_i,
    input  wire logic  bus_rx_data_i,
    input  wire logic  bus_active_i,
    input  wire logic  wake_detect_i,
    input  wire logic  overtemp_i,
    input  wire logic  bus_overcurrent_i,
    input  wire logic  status_clear_i,
    input  wire logic  event_ready_i,
    output logic       rx_data_o,
    output logic       diag_out_n_o,
    output logic       bus_plus_o,
    output logic       bus_minus_o,
    output logic       serial_data_out_oe_o,
    output bdm_status_t status_o,
    output logic       event_valid_o,
    output bdm_event_t event_o
);
    localparam int TW = $clog2(TX_TO_CYC + 1);

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_q;
    logic                 standby_n_q;

    // gather the pins by their package index, so the sync loop stays plain
    always_comb begin
        pin_raw[PIN_TX_DATA]  = tx_data_i;
        pin_raw[PIN_TX_EN_N]  = tx_enable_n_i;
        pin_raw[PIN_GUARD]    = guardian_enable_i;
        pin_raw[PIN_VCC_OK]   = vcc_ok_i;
        pin_raw[PIN_VCC_UV]   = vcc_uv_i;
        pin_raw[PIN_VIO_UV]   = logic_ref_supply_uv_i;
        pin_raw[PIN_BUS_RX]   = bus_rx_data_i;
        pin_raw[PIN_BUS_ACT]  = bus_active_i;
        pin_raw[PIN_WAKE]     = wake_detect_i;
        pin_raw[PIN_OVERTEMP] = overtemp_i;
        pin_raw[PIN_BUS_OC]   = bus_overcurrent_i;
    end

    // every pin but status_clear_i and event_ready_i crosses three flops before use
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
        bdm_sync_filt #(
            .FILT_CYC (1),
            .RST_VAL  (PIN_RST[i])
        ) u_sync (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .async_i   (pin_raw[i]),
            .level_o   (pin_q[i])
        );
    end

    bdm_sync_filt #(
        .FILT_CYC (FILTER_CYC),
        .RST_VAL  (STBY_N_RST)
    ) u_stby (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .async_i   (standby_n_i),
        .level_o   (standby_n_q)
    );

    logic tx_data;
    logic tx_en_n;
    logic guard;
    logic vcc_ok;
    logic uv;
    logic host_norm;
    assign tx_data   = pin_q[PIN_TX_DATA];
    assign tx_en_n   = pin_q[PIN_TX_EN_N];
    assign guard     = pin_q[PIN_GUARD];
    assign vcc_ok    = pin_q[PIN_VCC_OK];
    assign uv        = pin_q[PIN_VCC_UV] | pin_q[PIN_VIO_UV];
    assign host_norm = standby_n_q;

    // mode state machine
    bdm_mode_t mode_reg;
    bdm_mode_t mode_next;

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            MODE_OFF: begin
                if (vcc_ok) begin
                    mode_next = MODE_STBY;
                end
            end
            MODE_STBY: begin
                if (!vcc_ok) begin
                    mode_next = MODE_OFF;
                end else if (host_norm && !uv) begin
                    mode_next = MODE_NORM;
                end
            end
            MODE_NORM: begin
                if (!vcc_ok) begin
                    mode_next = MODE_OFF;
                end else if (uv || !host_norm) begin
                    mode_next = MODE_STBY;
                end
            end
            default: begin
                mode_next = MODE_OFF;
            end
        endcase
    end

    logic norm;
    logic stby;
    assign norm = (mode_reg == MODE_NORM);
    assign stby = (mode_reg == MODE_STBY);

    // transmitter arming and drive
    logic          en_n_d_reg;
    logic          tx_arm_reg;
    logic          tx_arm_next;
    logic          tx_on_reg;
    logic          tx_on_next;
    logic [TW-1:0] to_cnt_reg;
    logic [TW-1:0] to_cnt_next;
    logic          stop;

    always_comb begin
        stop        = status_o.tx_timeout | status_o.overtemp;
        tx_arm_next = tx_arm_reg;
        // standby drops everything the controller presents
        if (!norm || tx_en_n || !guard || stop) begin
            tx_arm_next = 1'b0;
        end else if (en_n_d_reg && !tx_en_n) begin
            tx_arm_next = 1'b1;
        end
        tx_on_next = tx_arm_next && (tx_on_reg || !tx_data);
        to_cnt_next = '0;
        if (tx_on_reg && to_cnt_reg != TW'(TX_TO_CYC)) begin
            to_cnt_next = to_cnt_reg + TW'(1);
        end
    end

    // status flags; a new event beats a clear in the same cycle
    bdm_status_t st_next;
    logic        to_set;
    logic        ot_set;
    logic        be_set;
    logic        gb_set;
    logic        wk_set;
    logic        uf_set;
    logic        uv_set;

    always_comb begin
        to_set = tx_on_reg && to_cnt_reg == TW'(TX_TO_CYC - 1);
        ot_set = tx_on_reg && pin_q[PIN_OVERTEMP];
        be_set = tx_on_reg && pin_q[PIN_BUS_OC];
        gb_set = norm && tx_arm_reg && !guard;
        wk_set = stby && !host_norm && pin_q[PIN_WAKE];
        uf_set = (mode_next == MODE_STBY) && !norm && host_norm && uv;
        uf_set = uf_set || (norm && uv && vcc_ok && host_norm);
        uv_set = (norm || stby) && uv;
        st_next = status_o;
        st_next.mode = mode_next;
        if (status_clear_i) begin
            st_next.uv_flag        = 1'b0;
            st_next.tx_timeout     = 1'b0;
            st_next.overtemp       = 1'b0;
            st_next.bus_error      = 1'b0;
            st_next.guardian_block = 1'b0;
            st_next.wake           = 1'b0;
            st_next.uv_forced      = 1'b0;
        end
        if (mode_next == MODE_NORM || mode_next == MODE_OFF) begin
            st_next.wake      = 1'b0;
            st_next.uv_forced = 1'b0;
        end
        if (!host_norm) begin
            st_next.uv_forced = 1'b0;
        end
        st_next.uv_flag        = st_next.uv_flag | uv_set;
        st_next.tx_timeout     = st_next.tx_timeout | to_set;
        st_next.overtemp       = st_next.overtemp | ot_set;
        st_next.bus_error      = st_next.bus_error | be_set;
        st_next.guardian_block = st_next.guardian_block | gb_set;
        st_next.wake           = st_next.wake | wk_set;
        st_next.uv_forced      = st_next.uv_forced | uf_set;
        if (norm) begin
            st_next.bus_activity_flag = pin_q[PIN_BUS_ACT];
        end
    end

    // pin outputs, all registered
    logic rx_next;
    logic diag_n_next;
    logic fault;

    always_comb begin
        fault = st_next.tx_timeout | st_next.overtemp | st_next.bus_error
              | st_next.guardian_block | uv_set;
        unique case (mode_next)
            MODE_NORM: begin
                diag_n_next = !fault;
                rx_next     = pin_q[PIN_BUS_RX];
            end
            MODE_STBY: begin
                if (host_norm) begin
                    diag_n_next = !st_next.uv_forced;
                end else begin
                    diag_n_next = !st_next.wake;
                end
                rx_next = diag_n_next;
            end
            default: begin
                diag_n_next = 1'b0;
                rx_next     = 1'b0;
            end
        endcase
    end

    // event queue to the host, held pending while the queue is full
    logic [EVT_COUNT-1:0] pend_reg;
    logic [EVT_COUNT-1:0] pend_next;
    logic [EVT_COUNT-1:0] pend_new;
    logic                 q_ready;
    bdm_event_t           q_word;
    logic                 fifo_valid;
    logic                 fifo_pop;
    bdm_event_t           fifo_word;
    logic                 ev_valid_next;
    bdm_event_t           ev_next;

    always_comb begin
        pend_new = '0;
        pend_new[EVT_WAKE]     = st_next.wake & !status_o.wake;
        pend_new[EVT_UV_FORCE] = st_next.uv_forced & !status_o.uv_forced;
        pend_new[EVT_TIMEOUT]  = st_next.tx_timeout & !status_o.tx_timeout;
        pend_new[EVT_OVERTEMP] = st_next.overtemp & !status_o.overtemp;
        pend_new[EVT_BUS_ERR]  = st_next.bus_error & !status_o.bus_error;
        pend_new[EVT_GUARD]    = st_next.guardian_block
                               & !status_o.guardian_block;
        q_word.code = '0;
        for (int i = EVT_COUNT - 1; i >= 0; i--) begin
            if (pend_reg[i]) begin
                q_word.code = 3'(i);
            end
        end
        pend_next = pend_reg;
        if (q_ready && pend_reg != '0) begin
            pend_next[q_word.code] = 1'b0;
        end
        pend_next = pend_next | pend_new;
    end

    bdm_fifo #(
        .WIDTH ($bits(bdm_event_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_evt_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (pend_reg != '0),
        .in_ready_o  (q_ready),
        .in_data_i   (q_word),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_word)
    );

    // pins stay on flops: a one-word output stage in front of the queue
    always_comb begin
        ev_valid_next = event_valid_o;
        ev_next       = event_o;
        fifo_pop      = 1'b0;
        if (!event_valid_o || event_ready_i) begin
            ev_valid_next = fifo_valid;
            ev_next       = fifo_word;
            fifo_pop      = fifo_valid;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            mode_reg             <= MODE_OFF;
            en_n_d_reg           <= 1'b1;
            tx_arm_reg           <= 1'b0;
            tx_on_reg            <= 1'b0;
            to_cnt_reg           <= '0;
            status_o             <= STATUS_RST;
            pend_reg             <= '0;
            event_valid_o        <= 1'b0;
            event_o              <= '0;
            rx_data_o            <= 1'b0;
            diag_out_n_o         <= 1'b0;
            bus_plus_o           <= 1'b0;
            bus_minus_o          <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
        end else begin
            mode_reg             <= mode_next;
            en_n_d_reg           <= tx_en_n;
            tx_arm_reg           <= tx_arm_next;
            tx_on_reg            <= tx_on_next;
            to_cnt_reg           <= to_cnt_next;
            status_o             <= st_next;
            pend_reg             <= pend_next;
            event_valid_o        <= ev_valid_next;
            event_o              <= ev_next;
            rx_data_o            <= rx_next;
            diag_out_n_o         <= diag_n_next;
            // both low is idle: no differential drive
            bus_plus_o           <= tx_on_next && tx_data;
            bus_minus_o          <= tx_on_next && !tx_data;
            serial_data_out_oe_o <= (mode_next != MODE_OFF);
        end
    end

endmodule : bdm_mode_ctrl

// [bdm_mode_ctrl_monitor.sv]
module bdm_mode_ctrl_monitor
    import bdm_pkg::*;
#(
    parameter int TX_TO_CYC = 20
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_b_i,
    input wire logic        tx_data_i,
    input wire logic        tx_enable_n_i,
    input wire logic        guardian_enable_i,
    input wire logic        standby_n_i,
    input wire logic        vcc_ok_i,
    input wire logic        vcc_uv_i,
    input wire logic        wake_detect_i,
    input wire logic        rx_data_o,
    input wire logic        diag_out_n_o,
    input wire logic        bus_plus_o,
    input wire logic        bus_minus_o,
    input wire logic        serial_data_out_oe_o,
    input wire bdm_status_t status_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    logic        nrm;
    logic        drv;
    logic [15:0] run_reg;
    logic [15:0] run_next;

    assign nrm = status_o.mode == MODE_NORM;
    assign drv = bus_plus_o | bus_minus_o;

    // length of the unbroken drive stretch, bounds a stuck transmitter
    always_comb begin
        run_next = (rst_b_i && drv) ? run_reg + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge sys_clk_i) begin
        run_reg <= run_next;
    end

    sequence s_host_stby;
        (!standby_n_i)[*6];
    endsequence
    sequence s_tx_low;
        (nrm && guardian_enable_i && !tx_enable_n_i && !tx_data_i
            && !status_o.tx_timeout && !status_o.overtemp)[*5];
    endsequence

    a_bus_one_state: assert property (
        !(bus_plus_o && bus_minus_o)) else $error("bus driven both ways");
    a_stby_no_drive: assert property (
        !nrm && !$past(nrm) |-> !drv) else $error("drive outside normal");
    a_off_pins_low: assert property (
        status_o.mode == MODE_OFF |-> !rx_data_o && !diag_out_n_o
            && !serial_data_out_oe_o) else $error("pins active in off");
    a_loss_goes_off: assert property (
        !vcc_ok_i |-> ##[1:5] status_o.mode == MODE_OFF)
        else $error("supply loss did not reach off");
    a_power_up_stby: assert property (
        $rose(vcc_ok_i) |-> ##[1:6] status_o.mode == MODE_STBY)
        else $error("power-up skipped standby");
    a_entry_needs_cmd: assert property (
        nrm && !$past(nrm) |-> $past(standby_n_i, 3) && !$past(vcc_uv_i, 3))
        else $error("normal entered without command");
    a_uv_leaves_norm: assert property (
        nrm && vcc_uv_i |-> ##[1:5] !nrm) else $error("uv kept normal");
    a_guard_cuts_tx: assert property (
        (!guardian_enable_i)[*5] |-> !drv) else $error("guard low, drive");
    a_tx_starts: assert property (
        $fell(tx_enable_n_i) && guardian_enable_i && nrm ##1 s_tx_low
            |-> bus_minus_o) else $error("transmit did not start");
    a_wake_flagged: assert property (
        s_host_stby ##0 ($rose(wake_detect_i) && status_o.mode == MODE_STBY)
            |-> ##[1:5] !diag_out_n_o && !rx_data_o)
        else $error("wake not shown in standby");
    a_drive_bounded: assert property (
        run_reg <= 16'(TX_TO_CYC + 1)) else $error("drive outlived time-out");
endmodule : bdm_mode_ctrl_monitor

bind bdm_mode_ctrl bdm_mode_ctrl_monitor #(.TX_TO_CYC(TX_TO_CYC)) mon_i (
    .sys_clk_i, .rst_b_i, .tx_data_i, .tx_enable_n_i, .guardian_enable_i,
    .standby_n_i, .vcc_ok_i, .vcc_uv_i, .wake_detect_i, .rx_data_o,
    .diag_out_n_o, .bus_plus_o, .bus_minus_o, .serial_data_out_oe_o,
    .status_o
);

// [bdm_bus_model.sv]
module bdm_bus_model
    import bdm_pkg::*;
(
    input  wire logic plus_i,
    input  wire logic minus_i,
    input  wire logic other_data_0_i,
    output logic      rx_o,
    output logic      active_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle reads high: only a negative difference gives a low receiver
    always_comb begin
        rx_o     = !(minus_i || other_data_0_i);
        active_o = plus_i || minus_i || other_data_0_i;
    end
endmodule : bdm_bus_model

// [test_bdm_mode_ctrl.sv]
module test_bdm_mode_ctrl
    import bdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        tx_en_n = 1'b1;
    logic        guard   = 1'b0;
    logic        stby_n  = 1'b0;
    logic        clk = 1'b0, rst_b = 1'b0, tx_data = 1'b0, vcc_ok = 1'b1;
    logic        vcc_uv = 1'b0, ref_uv = 1'b0, wake = 1'b0, otemp = 1'b0;
    logic        clr = 1'b0, ev_rdy = 1'b0, other0 = 1'b0, ovc = 1'b0;
    logic        bus_rx, bus_act, rx, diag, plus, minus, oe, ev_valid;
    bdm_status_t status;
    bdm_event_t  ev;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;

    bdm_mode_ctrl #(.TX_TO_CYC(20), .FILTER_CYC(2), .FIFO_DEPTH(4))
        bdm_mode_ctrl_i (
        .sys_clk_i(clk), .rst_b_i(rst_b), .tx_data_i(tx_data),
        .tx_enable_n_i(tx_en_n), .guardian_enable_i(guard),
        .standby_n_i(stby_n), .vcc_ok_i(vcc_ok), .vcc_uv_i(vcc_uv),
        .logic_ref_supply_uv_i(ref_uv), .bus_rx_data_i(bus_rx),
        .bus_active_i(bus_act), .wake_detect_i(wake), .overtemp_i(otemp),
        .bus_overcurrent_i(ovc), .status_clear_i(clr),
        .event_ready_i(ev_rdy), .rx_data_o(rx), .diag_out_n_o(diag),
        .bus_plus_o(plus), .bus_minus_o(minus),
        .serial_data_out_oe_o(oe), .status_o(status),
        .event_valid_o(ev_valid), .event_o(ev));

    bdm_bus_model bdm_bus_model_i (.plus_i(plus), .minus_i(minus),
        .other_data_0_i(other0), .rx_o(bus_rx), .active_o(bus_act));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // sample at the falling edge, after the rising edge has settled
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : look

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_mode(input bdm_mode_t m);
        for (int i = 0; i < 40 && status.mode !== m; i++) begin
            @(negedge clk);
        end
        chk(4'(status.mode), 4'(m));
    endtask : wait_mode

    task automatic pulse_clr;
        cyc(4);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
    endtask : pulse_clr

    task automatic take(input logic [2:0] code);
        chk(4'(ev_valid), 4'h1);
        chk(4'(ev.code), 4'(code));
        cyc(1);
        ev_rdy <= 1'b1;
        cyc(1);
        ev_rdy <= 1'b0;
        @(negedge clk);
    endtask : take

    task automatic conclude;
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        cyc(4);
        rst_b <= 1'b1;
        wait_mode(MODE_STBY);
        chk(4'({rx, diag, oe}), 4'h7);
        cyc(1);
        guard <= 1'b1;
        tx_en_n <= 1'b0;
        look(8);
        chk(4'({plus, minus}), 4'h0);
        cyc(1);
        tx_en_n <= 1'b1;
        stby_n <= 1'b1;
        cyc(1);
        stby_n <= 1'b0;
        look(10);
        chk(4'(status.mode), 4'(MODE_STBY));
        $display("test done: standby");
        cyc(1);
        stby_n <= 1'b1;
        wait_mode(MODE_NORM);
        cyc(1);
        other0 <= 1'b1;
        wake <= 1'b1;
        otemp <= 1'b1;
        ovc <= 1'b1;
        look(6);
        chk(4'({rx, status.bus_activity_flag}), 4'h1);
        chk(4'({diag, status.wake, status.overtemp}), 4'h4);
        chk(4'(status.bus_error), 4'h0);
        cyc(1);
        other0 <= 1'b0;
        wake <= 1'b0;
        otemp <= 1'b0;
        ovc <= 1'b0;
        look(6);
        chk(4'({rx, status.bus_activity_flag}), 4'h2);
        $display("test done: normal");
        cyc(1);
        tx_en_n <= 1'b0;
        look(6);
        chk(4'({plus, minus}), 4'h1);
        cyc(1);
        tx_data <= 1'b1;
        look(4);
        chk(4'({plus, minus}), 4'h2);
        cyc(1);
        guard <= 1'b0;
        look(5);
        chk(4'({plus, minus, diag}), 4'h0);
        cyc(1);
        guard <= 1'b1;
        tx_en_n <= 1'b1;
        tx_data <= 1'b0;
        pulse_clr();
        $display("test done: transmit");
        cyc(1);
        tx_en_n <= 1'b0;
        look(30);
        chk(4'({minus, status.tx_timeout, diag}), 4'h2);
        cyc(1);
        tx_en_n <= 1'b1;
        pulse_clr();
        $display("test done: time-out");
        cyc(1);
        vcc_uv <= 1'b1;
        wait_mode(MODE_STBY);
        look(1);
        chk(4'({rx, diag, status.uv_forced, status.uv_flag}), 4'h3);
        cyc(1);
        vcc_uv <= 1'b0;
        wait_mode(MODE_NORM);
        cyc(1);
        ref_uv <= 1'b1;
        wait_mode(MODE_STBY);
        cyc(1);
        ref_uv <= 1'b0;
        wait_mode(MODE_NORM);
        $display("test done: undervoltage");
        cyc(1);
        stby_n <= 1'b0;
        wait_mode(MODE_STBY);
        cyc(1);
        wake <= 1'b1;
        cyc(1);
        wake <= 1'b0;
        look(6);
        chk(4'({rx, diag}), 4'h0);
        take(EVT_GUARD);
        take(EVT_TIMEOUT);
        take(EVT_UV_FORCE);
        take(EVT_UV_FORCE);
        take(EVT_WAKE);
        chk(4'(ev_valid), 4'h0);
        $display("test done: events");
        cyc(1);
        vcc_ok <= 1'b0;
        stby_n <= 1'b1;
        wait_mode(MODE_OFF);
        chk(4'({rx, diag, oe}), 4'h0);
        cyc(1);
        vcc_ok <= 1'b1;
        wait_mode(MODE_STBY);
        wait_mode(MODE_NORM);
        $display("test done: power cycle");
        conclude();
    end
endmodule : test_bdm_mode_ctrl
